// *** core/wrmc_top.sv ***
// Replay controller with AHB-Lite registers, mode state machine and interrupt
// What this block does
// - Single-pass mode waits for a trigger, plays the block once, then stops.
// - Writing 1 to the single-pass select chooses single pass, 0 deselects it.
// - Any trigger, including the software trigger, starts single-pass output.
// - Looping mode replays the block after the trigger, restarting at sample zero.
// - The wrap from last to first sample leaves no idle sample slot.
// - Looping mode is single-pass 0 with loop-on-trigger 1.
// - Looping output only ends by a software stop.
// - Post-trigger mode is both selects at 0.
// - Post-trigger mode starts output at once and loops like looping mode.
// - In post-trigger mode a trigger leads to the post count of samples, then stop.
// - The replay length holds the samples per channel in one pass.
// - The post-trigger count holds the samples played after the trigger.
// - The post-trigger counter reaches at least 128 MSamples.
`timescale 1ns/1ns
module wrmc_top
    import wrmc_pkg::*;
#(
    parameter int ADDR_W = 32
) (
    // AHB-Lite clock and reset
    input  wire logic              hclk,
    input  wire logic              hresetn,
    // AHB-Lite slave
    input  wire logic              hsel,
    input  wire logic [ADDR_W-1:0] haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic      [31:0]       hrdata,
    output logic                   hreadyout,
    output logic                   hresp,
    // Trigger source
    input  wire logic              trig_in,
    // Sample stream to the converter channels
    output logic      [CNT_W-1:0]  sample_addr,
    output logic                   sample_valid,
    // Interrupt
    output logic                   irq
);

    // Register storage
    logic [31:0]     replay_length_r;
    logic [31:0]     post_trigger_count_r;
    logic            single_pass_select_r;
    logic            loop_on_trigger_select_r;
    logic [1:0]      irq_status_r;
    logic [1:0]      irq_mask_r;
    logic [31:0]     hrdata_r;

    // Data phase bookkeeping
    logic            wr_pend_r;
    logic [15:0]     wr_addr_r;

    // Captured run settings
    wrmc_mode_t      mode_r;
    logic [31:0]     len_r;
    logic [31:0]     post_r;

    // Replay state
    wrmc_state_t     state_r;
    wrmc_state_t     state_nxt;
    logic [CNT_W-1:0] remain_r;
    logic [CNT_W-1:0] remain_nxt;
    logic            triggered_r;

    // Address phase decode
    wire        addr_phase  = hsel && hready && htrans[HTRANS_ACTIVE_BIT];
    wire [15:0] ofs         = haddr[15:0];
    wire        upper_zero  = (haddr[ADDR_W-1:16] == '0);
    wire        rd_take     = addr_phase && !hwrite;

    // Data phase write decode
    wire        wr_len      = wr_pend_r && (wr_addr_r == OFS_REPLAY_LENGTH);
    wire        wr_post     = wr_pend_r && (wr_addr_r == OFS_POST_TRIGGER);
    wire        wr_single   = wr_pend_r && (wr_addr_r == OFS_SINGLE_PASS);
    wire        wr_loop     = wr_pend_r && (wr_addr_r == OFS_LOOP_ON_TRIGGER);
    wire        wr_cmd      = wr_pend_r && (wr_addr_r == OFS_COMMAND);
    wire        wr_mask     = wr_pend_r && (wr_addr_r == OFS_IRQ_MASK);

    wire        start_cmd   = wr_cmd && hwdata[CMD_START_BIT];
    wire        stop_cmd    = wr_cmd && hwdata[CMD_STOP_BIT];
    wire        sw_trig     = wr_cmd && hwdata[CMD_TRIG_BIT];
    wire        trig_any    = trig_in || sw_trig;
    wire        rd_irq_clr  = rd_take && upper_zero && (ofs == OFS_IRQ_STATUS);

    // Mode taken from the select registers when started
    wire wrmc_mode_t mode_sel = wrmc_mode_of(single_pass_select_r, loop_on_trigger_select_r);

    // Counter wrap point, guarded against a zero length
    wire [CNT_W-1:0] last_idx = (len_r == '0) ? '0 : CNT_W'(len_r - 32'h1);
    logic            at_last;
    logic [CNT_W-1:0] ctr_addr;

    wire start_ok   = start_cmd && !stop_cmd && (state_r == WRMC_ST_IDLE);
    wire playing    = (state_r == WRMC_ST_RUN) || (state_r == WRMC_ST_TAIL);
    wire ev_trig    = (state_r == WRMC_ST_ARMED && trig_any && !stop_cmd) ||
                      (state_r == WRMC_ST_RUN && mode_r == WRMC_MODE_POST &&
                       trig_any && !stop_cmd);
    wire ev_done    = !stop_cmd && playing && (state_nxt == WRMC_ST_IDLE);

    // Read data mux
    // State code sits in bits 5:4
    wire [31:0] status_word = {26'h0, 2'(state_r), 1'b0, triggered_r, playing,
                               state_r == WRMC_ST_ARMED};
    wire [31:0] rd_mux =
        !upper_zero                    ? 32'h0 :
        (ofs == OFS_REPLAY_LENGTH)     ? replay_length_r :
        (ofs == OFS_POST_TRIGGER)      ? post_trigger_count_r :
        (ofs == OFS_SINGLE_PASS)       ? {31'h0, single_pass_select_r} :
        (ofs == OFS_LOOP_ON_TRIGGER)   ? {31'h0, loop_on_trigger_select_r} :
        (ofs == OFS_STATUS)            ? status_word :
        (ofs == OFS_IRQ_STATUS)        ? {30'h0, irq_status_r} :
        (ofs == OFS_IRQ_MASK)          ? {30'h0, irq_mask_r} :
        32'h0;

    assign hrdata       = hrdata_r;
    assign hreadyout    = 1'b1;
    assign hresp        = 1'b0;
    assign sample_valid = playing;
    assign sample_addr  = ctr_addr;
    assign irq          = |(irq_status_r & irq_mask_r);

    // Bus address phase capture and read data
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 16'h0;
            hrdata_r  <= 32'h0;
        end else begin
            wr_pend_r <= addr_phase && hwrite && upper_zero && (hsize == 3'h2);
            wr_addr_r <= ofs;
            hrdata_r  <= rd_take ? rd_mux : hrdata_r;
        end
    end

    // Software registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            replay_length_r          <= RST_REPLAY_LENGTH;
            post_trigger_count_r     <= RST_POST_TRIGGER;
            single_pass_select_r     <= RST_SINGLE_PASS;
            loop_on_trigger_select_r <= RST_LOOP_ON_TRIGGER;
            irq_mask_r               <= RST_IRQ_MASK;
        end else begin
            if (wr_len) begin
                replay_length_r <= hwdata;
            end
            if (wr_post) begin
                post_trigger_count_r <= hwdata;
            end
            if (wr_single) begin
                single_pass_select_r <= hwdata[0];
            end
            if (wr_loop) begin
                loop_on_trigger_select_r <= hwdata[0];
            end
            if (wr_mask) begin
                irq_mask_r <= hwdata[1:0];
            end
        end
    end

    // Sticky events, a new event beats the read clear
    wire [1:0] irq_set = {ev_done, ev_trig};
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_status_r <= 2'h0;
        end else begin
            irq_status_r <= (rd_irq_clr ? 2'h0 : irq_status_r) | irq_set;
        end
    end

    // Settings held for the whole run
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode_r <= WRMC_MODE_SINGLE;
            len_r  <= RST_REPLAY_LENGTH;
            post_r <= RST_POST_TRIGGER;
        end else if (start_ok) begin
            mode_r <= mode_sel;
            len_r  <= replay_length_r;
            post_r <= post_trigger_count_r;
        end
    end

    // Replay state machine
    always_comb begin
        state_nxt  = state_r;
        remain_nxt = remain_r;
        case (state_r)
            WRMC_ST_IDLE: begin
                if (start_ok) begin
                    // Post-trigger plays at once, others wait
                    state_nxt = (mode_sel == WRMC_MODE_POST) ? WRMC_ST_RUN
                                                             : WRMC_ST_ARMED;
                end
            end
            WRMC_ST_ARMED: begin
                if (trig_any) begin
                    state_nxt = WRMC_ST_RUN;
                end
            end
            WRMC_ST_RUN: begin
                if (mode_r == WRMC_MODE_SINGLE && at_last) begin
                    state_nxt = WRMC_ST_IDLE;
                end else if (mode_r == WRMC_MODE_POST && trig_any) begin
                    remain_nxt = CNT_W'(post_r);
                    state_nxt  = (post_r == '0) ? WRMC_ST_IDLE : WRMC_ST_TAIL;
                end
                // Looping never leaves on its own
            end
            WRMC_ST_TAIL: begin
                remain_nxt = remain_r - CNT_W'(1);
                if (remain_r == CNT_W'(1)) begin
                    state_nxt = WRMC_ST_IDLE;
                end
            end
            default: begin
                state_nxt = WRMC_ST_IDLE;
            end
        endcase
        if (stop_cmd) begin
            state_nxt = WRMC_ST_IDLE;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_r     <= WRMC_ST_IDLE;
            remain_r    <= '0;
            triggered_r <= 1'b0;
        end else begin
            state_r     <= state_nxt;
            remain_r    <= remain_nxt;
            triggered_r <= start_ok ? 1'b0 : (triggered_r || ev_trig);
        end
    end

    // One sample per clock, wrapping with no gap
    wrmc_addr_ctr #(
        .W        (CNT_W)
    ) u_addr_ctr (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .clear    (start_ok),
        .advance  (playing),
        .last_idx (last_idx),
        .addr     (ctr_addr),
        .at_last  (at_last)
    );

    // Checks on the replay behaviour
    single_stop_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (state_r == WRMC_ST_RUN && mode_r == WRMC_MODE_SINGLE && at_last)
        |=> (state_r == WRMC_ST_IDLE) && !sample_valid
    ) else $error("single pass did not stop after last sample");

    sel_write_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        wr_single |=> single_pass_select_r == $past(hwdata[0])
    ) else $error("single pass select not written");

    trig_start_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (state_r == WRMC_ST_ARMED && sw_trig && !stop_cmd)
        |=> sample_valid && (sample_addr == '0)
    ) else $error("software trigger did not start output");

    wrap_nogap_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (state_r == WRMC_ST_RUN && mode_r != WRMC_MODE_SINGLE && at_last && !stop_cmd
         && !(mode_r == WRMC_MODE_POST && trig_any && post_r == '0))
        |=> sample_valid && (sample_addr == '0)
    ) else $error("gap or wrong address at wrap");

    loop_keeps_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (state_r == WRMC_ST_RUN && mode_r == WRMC_MODE_LOOP && !stop_cmd)
        |=> state_r == WRMC_ST_RUN
    ) else $error("looping ended without stop");

    post_immediate_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (start_ok && mode_sel == WRMC_MODE_POST) |=> sample_valid ##1 sample_valid
        || state_r == WRMC_ST_IDLE
    ) else $error("post-trigger mode did not start at once");

    tail_end_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (state_r == WRMC_ST_TAIL && remain_r == CNT_W'(1) && !stop_cmd)
        |=> (state_r == WRMC_ST_IDLE) && !sample_valid && irq_status_r[IRQ_DONE_BIT]
    ) else $error("post-trigger tail did not end on its count");

    tail_load_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (state_r == WRMC_ST_RUN && mode_r == WRMC_MODE_POST && trig_any && !stop_cmd
         && post_r != '0)
        |=> (state_r == WRMC_ST_TAIL) && (remain_r == CNT_W'(post_r)) && sample_valid
    ) else $error("post-trigger count not loaded at trigger");

    tail_step_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (state_r == WRMC_ST_TAIL && remain_r != CNT_W'(1) && !stop_cmd)
        |=> (state_r == WRMC_ST_TAIL) && (remain_r == $past(remain_r) - CNT_W'(1))
    ) else $error("post-trigger tail count did not step");

    stop_idle_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        stop_cmd |=> (state_r == WRMC_ST_IDLE) && !sample_valid
    ) else $error("stop command did not end output");

    done_flag_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        ev_done |=> irq_status_r[IRQ_DONE_BIT]
    ) else $error("self-stop event not recorded");

    armed_wait_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (state_r == WRMC_ST_ARMED && !trig_any && !stop_cmd)
        |=> (state_r == WRMC_ST_ARMED) && !sample_valid
    ) else $error("output began without a trigger");

    loop_arm_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (start_ok && !single_pass_select_r && loop_on_trigger_select_r)
        |=> (state_r == WRMC_ST_ARMED) && (mode_r == WRMC_MODE_LOOP)
    ) else $error("looping mode not armed at start");

    addr_bound_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (sample_valid && len_r != '0) |-> sample_addr <= last_idx
    ) else $error("sample address beyond replay length");

    hold_mode_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (state_r != WRMC_ST_IDLE) |=> $stable(mode_r) && $stable(len_r) && $stable(post_r)
    ) else $error("settings changed during output");

endmodule

// *** core/wrmc_pkg.sv ***
// Shared constants and types of the waveform replay mode controller
package wrmc_pkg;

    // Register byte offsets
    localparam logic [15:0] OFS_REPLAY_LENGTH   = 16'h2710;
    localparam logic [15:0] OFS_POST_TRIGGER    = 16'h2774;
    localparam logic [15:0] OFS_SINGLE_PASS     = 16'ha028;
    localparam logic [15:0] OFS_LOOP_ON_TRIGGER = 16'ha08c;
    localparam logic [15:0] OFS_COMMAND         = 16'h0000;
    localparam logic [15:0] OFS_STATUS          = 16'h0004;
    localparam logic [15:0] OFS_IRQ_STATUS      = 16'h0008;
    localparam logic [15:0] OFS_IRQ_MASK        = 16'h000c;

    // Reset values
    localparam logic [31:0] RST_REPLAY_LENGTH   = 32'h0000_0020;
    localparam logic [31:0] RST_POST_TRIGGER    = 32'h0000_0020;
    localparam logic        RST_SINGLE_PASS     = 1'b0;
    localparam logic        RST_LOOP_ON_TRIGGER = 1'b0;
    localparam logic [1:0]  RST_IRQ_MASK        = 2'h0;

    // Command register bits, write one to act
    localparam int CMD_START_BIT = 0;
    localparam int CMD_STOP_BIT  = 1;
    localparam int CMD_TRIG_BIT  = 2;

    // Status register bits
    localparam int STS_WAITING_BIT   = 0;
    localparam int STS_RUNNING_BIT   = 1;
    localparam int STS_TRIGGERED_BIT = 2;
    localparam int STS_STATE_LSB     = 4;

    // Interrupt status and mask bits
    localparam int IRQ_TRIG_BIT = 0;
    localparam int IRQ_DONE_BIT = 1;

    // AHB transfer type bit that marks NONSEQ or SEQ
    localparam int HTRANS_ACTIVE_BIT = 1;

    // Counter width: covers 128 MSamples of post-trigger count with margin
    localparam int CNT_W = 32;

    typedef enum logic [1:0] {
        WRMC_MODE_SINGLE = 2'b00,
        WRMC_MODE_LOOP   = 2'b01,
        WRMC_MODE_POST   = 2'b10
    } wrmc_mode_t;

    typedef enum logic [1:0] {
        WRMC_ST_IDLE  = 2'b00,
        WRMC_ST_ARMED = 2'b01,
        WRMC_ST_RUN   = 2'b10,
        WRMC_ST_TAIL  = 2'b11
    } wrmc_state_t;

    // Single pass wins over looping; both clear selects post-trigger
    function automatic wrmc_mode_t wrmc_mode_of(input logic single, input logic loop);
        if (single) begin
            return WRMC_MODE_SINGLE;
        end else if (loop) begin
            return WRMC_MODE_LOOP;
        end else begin
            return WRMC_MODE_POST;
        end
    endfunction

endpackage

// *** core/wrmc_addr_ctr.sv ***
// Sample address counter that wraps at the end of the replay block
`timescale 1ns/1ns
module wrmc_addr_ctr
    import wrmc_pkg::*;
#(
    parameter int W = 32
) (
    // Clock and reset
    input  wire logic         hclk,
    input  wire logic         hresetn,
    // Control
    input  wire logic         clear,
    input  wire logic         advance,
    input  wire logic [W-1:0] last_idx,
    // State
    output logic      [W-1:0] addr,
    output logic              at_last
);

    logic [W-1:0] addr_r;
    logic [W-1:0] addr_nxt;

    assign at_last = (addr_r == last_idx);
    assign addr    = addr_r;

    // Wrap straight to zero, no idle slot
    assign addr_nxt = clear   ? '0 :
                      advance ? (at_last ? '0 : addr_r + W'(1)) :
                      addr_r;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            addr_r <= '0;
        end else begin
            addr_r <= addr_nxt;
        end
    end

endmodule

// *** tb/wrmc_dac_model.sv ***
// Model of the converter channels and the external trigger source
`timescale 1ns/1ns
module wrmc_dac_model (
    // Clock
    input  wire logic        hclk,
    // Sample stream from the controller
    input  wire logic [31:0] sample_addr,
    input  wire logic        sample_valid,
    // Trigger line
    output logic             trig_in
);
    int n_samples;

    initial begin
        trig_in = 1'b0;
        n_samples = 0;
    end

    // One converter load per valid cycle, taken at the rising edge
    always @(posedge hclk) begin
        if (sample_valid === 1'b1) begin
            n_samples++;
        end
    end

    // One-cycle trigger pulse; the line rests low between pulses
    task automatic pulse();
        @(posedge hclk);
        trig_in <= 1'b1;
        @(posedge hclk);
        trig_in <= 1'b0;
    endtask
endmodule

// *** tb/waveform_replay_mode_control_tb.sv ***
// Self-checking bench of the waveform replay mode controller
`timescale 1ns/1ns
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin fails++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module waveform_replay_mode_control_tb;
    import wrmc_pkg::*;
    logic             hclk;
    logic             hresetn;
    logic             hsel;
    logic [31:0]      haddr;
    logic [1:0]       htrans;
    logic             hwrite;
    logic [2:0]       hsize;
    logic [31:0]      hwdata;
    logic [31:0]      hrdata;
    logic             hreadyout;
    logic             hresp;
    logic             trig_in;
    logic [CNT_W-1:0] sample_addr;
    logic             sample_valid;
    logic             irq;
    logic [31:0]      rd_val;
    logic [31:0]      rexp;
    logic [31:0]      sexp;
    logic [31:0]      lf;
    logic [31:0]      sq[$];
    logic [31:0]      rq[$];
    event             rd_ev;
    int               fails;
    int               n_tests;
    int               n_exp;

    wrmc_top #(.ADDR_W(32)) dut_u (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .trig_in(trig_in),
        .sample_addr(sample_addr), .sample_valid(sample_valid), .irq(irq));

    wrmc_dac_model dac_u (.hclk(hclk), .sample_addr(sample_addr),
        .sample_valid(sample_valid), .trig_in(trig_in));

    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // Single word transfer; waits for hready at both phases
    task automatic bus(input logic w, input logic [15:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        haddr  <= {16'h0000, a};
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        `CHK(hresp, 1'b0)
        if (!w) begin
            rd_val = hrdata;
            -> rd_ev;
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rd(input logic [15:0] a, input logic [31:0] e);
        rq.push_back(e);
        bus(1'b0, a, 32'h0000_0000);
    endtask

    task automatic push_run(input int len, input int n);
        for (int i = 0; i < n; i++) begin
            sq.push_back(32'(i % len));
        end
        n_exp += n;
    endtask

    // Waits for all expected samples, then checks that the stream went quiet
    task automatic drain();
        int k;
        k = 0;
        while (sq.size() > 0 && k < 500) begin
            @(posedge hclk);
            k++;
        end
        repeat (4) @(posedge hclk);
        `CHK(32'(sq.size()), 32'h0000_0000)
        `CHK(sample_valid, 1'b0)
        `CHK(32'(dac_u.n_samples), 32'(n_exp))
        sq.delete();
    endtask

    task automatic end_sim();
        $display("Comparisons %0d, mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    always @(rd_ev) begin
        rexp = rq.pop_front();
        `CHK(rd_val, rexp)
    end

    always @(posedge hclk) begin
        if (sample_valid === 1'b1) begin
            sexp = (sq.size() > 0) ? sq.pop_front() : 32'hxxxx_xxxx;
            `CHK(sample_addr, sexp)
        end
    end

    // Whole run is under a thousand cycles; this allows several times that
    initial begin
        #50000;
        fails++;
        end_sim();
    end

    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0000_0000;
        fails = 0;
        n_tests = 0;
        n_exp = 0;
        lf = 32'h0000_0014;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        rd(OFS_REPLAY_LENGTH, RST_REPLAY_LENGTH);
        rd(OFS_POST_TRIGGER, RST_POST_TRIGGER);
        rd(OFS_SINGLE_PASS, {31'h0, RST_SINGLE_PASS});
        rd(OFS_LOOP_ON_TRIGGER, {31'h0, RST_LOOP_ON_TRIGGER});
        rd(OFS_STATUS, 32'h0000_0000);
        wr(16'h0100, 32'hffff_ffff);
        rd(16'h0100, 32'h0000_0000);
        for (int i = 0; i < 4; i++) begin
            lf = lfsr(lf);
            wr(OFS_REPLAY_LENGTH, lf & 32'hffff_ffe0);
            rd(OFS_REPLAY_LENGTH, lf & 32'hffff_ffe0);
            wr(OFS_POST_TRIGGER, {lf[15:0], lf[31:16]} & 32'hffff_ffe0);
            rd(OFS_POST_TRIGGER, {lf[15:0], lf[31:16]} & 32'hffff_ffe0);
        end
        // Single pass armed by the trigger line
        wr(OFS_REPLAY_LENGTH, 32'h0000_0020);
        wr(OFS_SINGLE_PASS, 32'h0000_0001);
        rd(OFS_SINGLE_PASS, 32'h0000_0001);
        wr(OFS_COMMAND, 32'h0000_0001 << CMD_START_BIT);
        rd(OFS_STATUS, 32'h0000_0011);
        push_run(32, 32);
        dac_u.pulse();
        drain();
        rd(OFS_IRQ_STATUS, 32'h0000_0003);
        // Looping, software trigger, length rewritten mid-run
        wr(OFS_SINGLE_PASS, 32'h0000_0000);
        rd(OFS_SINGLE_PASS, 32'h0000_0000);
        wr(OFS_LOOP_ON_TRIGGER, 32'h0000_0001);
        wr(OFS_COMMAND, 32'h0000_0001 << CMD_START_BIT);
        push_run(32, 36);
        wr(OFS_COMMAND, 32'h0000_0001 << CMD_TRIG_BIT);
        wr(OFS_REPLAY_LENGTH, 32'h0000_0040);
        repeat (30) @(posedge hclk);
        wr(OFS_COMMAND, 32'h0000_0001 << CMD_STOP_BIT);
        drain();
        rd(OFS_IRQ_STATUS, 32'h0000_0001);
        // Post-trigger: runs at once, trigger after two samples
        wr(OFS_LOOP_ON_TRIGGER, 32'h0000_0000);
        wr(OFS_REPLAY_LENGTH, 32'h0000_0020);
        wr(OFS_POST_TRIGGER, 32'h0000_0020);
        push_run(32, 34);
        wr(OFS_COMMAND, 32'h0000_0001 << CMD_START_BIT);
        dac_u.pulse();
        drain();
        `CHK(irq, 1'b0)
        wr(OFS_IRQ_MASK, 32'h0000_0002);
        @(posedge hclk);
        #1;
        `CHK(irq, 1'b1)
        rd(OFS_IRQ_STATUS, 32'h0000_0003);
        rd(OFS_IRQ_STATUS, 32'h0000_0000);
        `CHK(irq, 1'b0)
        end_sim();
    end
endmodule
